// ==== design/accum_regs.svh ====
// Constants for the accumulator exchange and stack datapath
// What this block does
// - Exchange swaps accumulator with addressed byte
// - Nibble swap exchanges accumulator high and low
// - Swap equals four left rotations without carry
// - Low-nibble exchange keeps both high nibbles
// - Eleven opcodes select low-nibble exchange
// - Decimal adjust yields packed BCD sum
// - Calls, returns, interrupts use stack automatically
// - Store increments pointer, then writes byte
// - Load reads byte, then decrements pointer
// - Pointer resets to 07, first store at 08
// - Stack is last in, first out
// - Stack lives only in 256-byte scratch RAM
// - Store source is direct address operand
// - Load destination is direct address operand
// - No stack bounds check; overflow overwrites RAM
`ifndef ACCUM_REGS_SVH
`define ACCUM_REGS_SVH

// ************************************************************
// Special-function addresses and reset values
// ************************************************************
`define SFR_BASE        8'h80
`define ADDR_A_REG_SFR  8'hE0
`define ADDR_SP_SFR     8'h81
`define SP_RESET        8'h07

// ************************************************************
// Opcode encodings
// ************************************************************
`define OPC_ROTATE_LEFT 8'h23
`define OPC_SHORT_CALL  8'h11
`define OPC_LONG_CALL   8'h12
`define OPC_SUB_EXIT    8'h22
`define OPC_ISR_EXIT    8'h32
`define OPC_PUSH        8'hC0
`define OPC_SWAP        8'hC4
`define OPC_ACCUM_TRADE 8'hC5
`define OPC_POP         8'hD0
`define OPC_DEC_ADJUST  8'hD4
`define OPC_LOW_FIRST   8'hD5
`define OPC_LOW_IND0    8'hD6
`define OPC_LOW_IND1    8'hD7
`define OPC_LOW_LAST    8'hDF

// ************************************************************
// Decimal adjust constants
// ************************************************************
`define BCD_DIGIT_MAX   4'h9
`define BCD_LOW_FIX     9'h006
`define BCD_HIGH_FIX    9'h060

`endif

// ==== design/accum_pkg.sv ====
// Types shared by the accumulator exchange and stack datapath
package accum_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ACCUM_TRADE,
    OP_SWAP,
    OP_ROTATE_LEFT,
    OP_LOW_TRADE,
    OP_DEC_ADJUST,
    OP_PUSH,
    OP_POP,
    OP_CALL,
    OP_RETURN
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CALL2,
    ST_RET2
  } state_type;

endpackage

// ==== design/ram_port_if.sv ====
// Port bundle between the datapath and its scratch RAM
`timescale 1ns/1ps
`default_nettype none
interface ram_port_if;
  logic       clk_en;
  logic [7:0] raddr_a;
  logic [7:0] raddr_b;
  logic [7:0] rdata_a;
  logic [7:0] rdata_b;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;

  modport ctrl (
    output clk_en, raddr_a, raddr_b, we, waddr, wdata,
    input  rdata_a, rdata_b
  );
  modport mem (
    input  clk_en, raddr_a, raddr_b, we, waddr, wdata,
    output rdata_a, rdata_b
  );
endinterface
`default_nettype wire

// ==== design/scratch_ram.sv ====
// On-chip scratch RAM, 256 bytes, two read ports, one write port
`timescale 1ns/1ps
`default_nettype none
module scratch_ram (
  input wire logic core_clk,
  ram_port_if.mem  port
);

  logic [7:0] mem_r [0:255];

  // Contents are not reset, as in the real part
  always_ff @(posedge core_clk)
  begin
    if (port.clk_en && port.we)
    begin
      mem_r[port.waddr] <= port.wdata;
    end
  end

  assign port.rdata_a = mem_r[port.raddr_a];
  assign port.rdata_b = mem_r[port.raddr_b];

endmodule // scratch_ram
`default_nettype wire

// ==== design/accum_exchange_stack_ops.sv ====
// Accumulator exchange, nibble, decimal adjust and stack datapath
`timescale 1ns/1ps
`default_nettype none
`include "accum_regs.svh"
module accum_exchange_stack_ops (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        op_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand,
  input  wire logic [15:0] ret_addr,
  input  wire logic        irq_enter,
  input  wire logic        cy_in,
  input  wire logic        ac_in,
  output logic             op_ready_r,
  output logic             done_r,
  output logic [7:0]       acc_r,
  output logic [7:0]       sp_r,
  output logic             cy_r,
  output logic [15:0]      ret_pc_r
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_r;
  logic rst_n_sync;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else if (clk_en)
    begin
      rst_meta_r <= 1'b1;
      rst_n_sync <= rst_meta_r;
    end
  end

  // ************************************************************
  // Decode
  // ************************************************************
  function automatic accum_pkg::op_type decode_op(
    input logic [7:0] opc,
    input logic       irq
  );
    accum_pkg::op_type res;
    res = accum_pkg::OP_NONE;
    if (irq)
      res = accum_pkg::OP_CALL;
    else if (opc >= `OPC_LOW_FIRST && opc <= `OPC_LOW_LAST)
      res = accum_pkg::OP_LOW_TRADE;
    else
    begin
      case (opc)
        `OPC_ACCUM_TRADE: res = accum_pkg::OP_ACCUM_TRADE;
        `OPC_SWAP:        res = accum_pkg::OP_SWAP;
        `OPC_ROTATE_LEFT: res = accum_pkg::OP_ROTATE_LEFT;
        `OPC_DEC_ADJUST:  res = accum_pkg::OP_DEC_ADJUST;
        `OPC_PUSH:        res = accum_pkg::OP_PUSH;
        `OPC_POP:         res = accum_pkg::OP_POP;
        `OPC_SHORT_CALL,
        `OPC_LONG_CALL:   res = accum_pkg::OP_CALL;
        `OPC_SUB_EXIT,
        `OPC_ISR_EXIT:    res = accum_pkg::OP_RETURN;
        default:          res = accum_pkg::OP_NONE;
      endcase
    end
    return res;
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] v);
    return {v[6:0], v[7]};
  endfunction

  // ************************************************************
  // Datapath
  // ************************************************************
  ram_port_if ram ();

  scratch_ram u_ram (
    .core_clk (core_clk),
    .port     (ram.mem)
  );

  accum_pkg::op_type    cur_op;
  accum_pkg::state_type state_r;
  accum_pkg::state_type state_nxt;
  logic                 fire;
  logic                 ind_sel;
  logic                 is_pop_side;
  logic [7:0]           src_addr;
  logic [7:0]           dir_val;
  logic [7:0]           tgt_val;
  logic [7:0]           sp_inc;
  logic [8:0]           bcd_lo;
  logic [8:0]           bcd_hi;
  logic [7:0]           hold_r;
  logic [7:0]           hold_nxt;
  logic [7:0]           acc_nxt;
  logic [7:0]           sp_nxt;
  logic                 cy_nxt;
  logic [15:0]          ret_pc_nxt;
  logic                 done_nxt;
  logic                 wb_en;
  logic [7:0]           wb_addr;
  logic [7:0]           wb_val;

  assign cur_op  = decode_op(opcode, irq_enter);
  assign fire    = clk_en && op_valid && op_ready_r;
  assign ind_sel = (opcode == `OPC_LOW_IND0) || (opcode == `OPC_LOW_IND1);
  assign sp_inc  = 8'(sp_r + 8'h01);
  assign is_pop_side = (state_r == accum_pkg::ST_RET2) ||
                       (cur_op == accum_pkg::OP_POP) ||
                       (cur_op == accum_pkg::OP_RETURN);

  // Port A reads the direct operand, a bank register or a pointer
  always_comb
  begin
    if (cur_op == accum_pkg::OP_LOW_TRADE && ind_sel)
      src_addr = {7'h00, opcode[0]};
    else if (cur_op == accum_pkg::OP_LOW_TRADE && opcode[3])
      src_addr = {5'h00, opcode[2:0]};
    else
      src_addr = operand;
  end

  // Stack reads go through port B on the pointer, always RAM
  assign ram.clk_en  = clk_en;
  assign ram.raddr_a = src_addr;
  assign ram.raddr_b = is_pop_side ? sp_r : ram.rdata_a;

  always_comb
  begin
    if (src_addr < `SFR_BASE)
      dir_val = ram.rdata_a;
    else if (src_addr == `ADDR_A_REG_SFR)
      dir_val = acc_r;
    else if (src_addr == `ADDR_SP_SFR)
      dir_val = sp_r;
    else
      dir_val = 8'h00;
  end

  assign tgt_val = ind_sel ? ram.rdata_b : dir_val;

  // Low digit first; its carry feeds the high digit test
  always_comb
  begin
    bcd_lo = {1'b0, acc_r};
    if (acc_r[3:0] > `BCD_DIGIT_MAX || ac_in)
      bcd_lo = 9'(bcd_lo + `BCD_LOW_FIX);
    bcd_hi = bcd_lo;
    if (bcd_lo[7:4] > `BCD_DIGIT_MAX || cy_in || bcd_lo[8])
      bcd_hi = 9'(bcd_lo + `BCD_HIGH_FIX);
  end

  always_comb
  begin
    acc_nxt    = acc_r;
    sp_nxt     = sp_r;
    cy_nxt     = cy_r;
    ret_pc_nxt = ret_pc_r;
    hold_nxt   = hold_r;
    state_nxt  = state_r;
    done_nxt   = 1'b0;
    wb_en      = 1'b0;
    wb_addr    = operand;
    wb_val     = 8'h00;
    ram.we     = 1'b0;
    ram.waddr  = 8'h00;
    ram.wdata  = 8'h00;
    case (state_r)
      accum_pkg::ST_IDLE:
      begin
        if (fire)
        begin
          done_nxt = 1'b1;
          case (cur_op)
            accum_pkg::OP_ACCUM_TRADE:
            begin
              acc_nxt = dir_val;
              wb_en   = 1'b1;
              wb_val  = acc_r;
            end
            accum_pkg::OP_SWAP:
              acc_nxt = {acc_r[3:0], acc_r[7:4]};
            accum_pkg::OP_ROTATE_LEFT:
              acc_nxt = rotl(acc_r);
            accum_pkg::OP_LOW_TRADE:
            begin
              acc_nxt = {acc_r[7:4], tgt_val[3:0]};
              if (ind_sel)
              begin
                ram.we    = 1'b1;
                ram.waddr = ram.rdata_a;
                ram.wdata = {tgt_val[7:4], acc_r[3:0]};
              end
              else
              begin
                wb_en   = 1'b1;
                wb_addr = src_addr;
                wb_val  = {tgt_val[7:4], acc_r[3:0]};
              end
            end
            accum_pkg::OP_DEC_ADJUST:
            begin
              acc_nxt = bcd_hi[7:0];
              cy_nxt  = cy_in | bcd_lo[8] | bcd_hi[8];
            end
            accum_pkg::OP_PUSH:
            begin
              sp_nxt    = sp_inc;
              ram.we    = 1'b1;
              ram.waddr = sp_inc;
              ram.wdata = dir_val;
            end
            accum_pkg::OP_POP:
            begin
              sp_nxt = 8'(sp_r - 8'h01);
              wb_en  = 1'b1;
              wb_val = ram.rdata_b;
            end
            accum_pkg::OP_CALL:
            begin
              sp_nxt    = sp_inc;
              ram.we    = 1'b1;
              ram.waddr = sp_inc;
              ram.wdata = ret_addr[7:0];
              hold_nxt  = ret_addr[15:8];
              state_nxt = accum_pkg::ST_CALL2;
              done_nxt  = 1'b0;
            end
            accum_pkg::OP_RETURN:
            begin
              sp_nxt    = 8'(sp_r - 8'h01);
              hold_nxt  = ram.rdata_b;
              state_nxt = accum_pkg::ST_RET2;
              done_nxt  = 1'b0;
            end
            default:
              acc_nxt = acc_r;
          endcase
        end
      end
      accum_pkg::ST_CALL2:
      begin
        sp_nxt    = sp_inc;
        ram.we    = 1'b1;
        ram.waddr = sp_inc;
        ram.wdata = hold_r;
        state_nxt = accum_pkg::ST_IDLE;
        done_nxt  = 1'b1;
      end
      accum_pkg::ST_RET2:
      begin
        sp_nxt     = 8'(sp_r - 8'h01);
        ret_pc_nxt = {hold_r, ram.rdata_b};
        state_nxt  = accum_pkg::ST_IDLE;
        done_nxt   = 1'b1;
      end
      default:
        state_nxt = accum_pkg::ST_IDLE;
    endcase
    // Direct write-back: low half is RAM, upper half is SFR space
    if (wb_en)
    begin
      if (wb_addr < `SFR_BASE)
      begin
        ram.we    = 1'b1;
        ram.waddr = wb_addr;
        ram.wdata = wb_val;
      end
      else if (wb_addr == `ADDR_A_REG_SFR)
        acc_nxt = wb_val;
      else if (wb_addr == `ADDR_SP_SFR)
        sp_nxt = wb_val;      // Popping into the pointer overrides the step
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      state_r <= accum_pkg::ST_IDLE;
    else if (clk_en)
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      sp_r <= `SP_RESET;
    else if (clk_en)
      sp_r <= sp_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      acc_r <= 8'h00;
      cy_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      acc_r <= acc_nxt;
      cy_r  <= cy_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      hold_r     <= 8'h00;
      ret_pc_r   <= 16'h0000;
      done_r     <= 1'b0;
      op_ready_r <= 1'b0;
    end
    else if (clk_en)
    begin
      hold_r     <= hold_nxt;
      ret_pc_r   <= ret_pc_nxt;
      done_r     <= done_nxt;
      op_ready_r <= (state_nxt == accum_pkg::ST_IDLE);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_sync);

  trade_acc_load_a: assert property (
    fire && cur_op == accum_pkg::OP_ACCUM_TRADE && operand < `SFR_BASE
    |-> ram.we && ram.wdata == acc_r ##1 acc_r == $past(dir_val))
    else $error("exchange did not trade accumulator and byte");
  swap_nibble_a: assert property (
    fire && cur_op == accum_pkg::OP_SWAP
    |=> acc_r[7:4] == $past(acc_r[3:0]) && acc_r[3:0] == $past(acc_r[7:4]))
    else $error("nibble swap result wrong");
  swap_four_rotl_a: assert property (
    fire && cur_op == accum_pkg::OP_SWAP
    |=> acc_r == rotl(rotl(rotl(rotl($past(acc_r))))))
    else $error("swap differs from four left rotations");
  // Only RAM targets show the traded byte on the write port
  low_trade_keep_a: assert property (
    fire && cur_op == accum_pkg::OP_LOW_TRADE && src_addr < `SFR_BASE
    |-> ram.wdata[3:0] == acc_r[3:0] ##1
        acc_r[7:4] == $past(acc_r[7:4]) && acc_r[3:0] == $past(tgt_val[3:0]))
    else $error("low-nibble exchange wrong");
  low_code_map_a: assert property (
    !irq_enter && opcode >= `OPC_LOW_FIRST && opcode <= `OPC_LOW_LAST
    |-> cur_op == accum_pkg::OP_LOW_TRADE)
    else $error("low-nibble opcode not decoded");
  dec_adjust_a: assert property (
    fire && cur_op == accum_pkg::OP_DEC_ADJUST && !cy_in && !ac_in
    && acc_r == 8'h5D |=> acc_r == 8'h63)
    else $error("decimal adjust of 5D did not give 63");
  push_order_a: assert property (
    fire && cur_op == accum_pkg::OP_PUSH
    |-> ram.we && ram.waddr == sp_inc ##1 sp_r == $past(sp_inc))
    else $error("store did not pre-increment pointer");
  pop_order_a: assert property (
    fire && cur_op == accum_pkg::OP_POP && operand != `ADDR_SP_SFR
    |-> ram.raddr_b == sp_r ##1 sp_r == 8'($past(sp_r) - 8'h01))
    else $error("load did not post-decrement pointer");
  sp_reset_a: assert property (
    $rose(rst_n_sync) |-> sp_r == `SP_RESET)
    else $error("pointer not 07 after reset");
  call_store_a: assert property (
    fire && cur_op == accum_pkg::OP_CALL
    |=> state_r == accum_pkg::ST_CALL2 && sp_r == $past(sp_inc))
    else $error("call did not store return address");

  cover_push_pop_c: cover property (
    fire && cur_op == accum_pkg::OP_PUSH ##[1:8]
    fire && cur_op == accum_pkg::OP_POP);
  cover_call_ret_c: cover property (
    fire && cur_op == accum_pkg::OP_CALL ##[2:20]
    fire && cur_op == accum_pkg::OP_RETURN);
  cover_bcd_carry_c: cover property (
    fire && cur_op == accum_pkg::OP_DEC_ADJUST ##1 cy_r);

endmodule // accum_exchange_stack_ops
`default_nettype wire

// ==== tb/accum_exchange_stack_ops_tb_top.sv ====
// Self-checking bench for the accumulator exchange and stack datapath
`timescale 1ns/1ps
`default_nettype none
`include "accum_regs.svh"
module accum_exchange_stack_ops_tb_top;
  // ************************************************************
  // Signals and reference state
  // ************************************************************
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  sp;
    logic        cy;
    logic [15:0] pc;
  } note_type;

  localparam int TD = 1;
  logic        core_clk = 1'b0;
  logic        rstn;
  logic        clk_en;
  logic        op_valid;
  logic [7:0]  opcode;
  logic [7:0]  operand;
  logic [15:0] ret_addr;
  logic        irq_enter;
  logic        cy_in;
  logic        ac_in;
  logic        op_ready_r;
  logic        done_r;
  logic [7:0]  acc_r;
  logic [7:0]  sp_r;
  logic        cy_r;
  logic [15:0] ret_pc_r;
  logic [7:0]  m_acc;
  logic [7:0]  m_sp;
  logic        m_cy;
  logic [15:0] m_pc;
  logic [7:0]  m_ram [256];
  logic [31:0] seed;
  logic [31:0] r;
  logic [7:0]  a0;
  logic        pin_en;
  logic [17:0] pin_v;
  note_type    notes [$];
  note_type    nt;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          i;
  int          k;

  logic [7:0] opc_tab [14] = '{8'hC5, 8'hC4, 8'h23, 8'hD4, 8'hD5, 8'hD6,
    8'hDB, 8'hC0, 8'hD0, 8'h11, 8'h12, 8'h22, 8'h32, 8'hA5};

  always #2.5 core_clk = ~core_clk;

  accum_exchange_stack_ops i_accum_exchange_stack_ops (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .op_valid   (op_valid),
    .opcode     (opcode),
    .operand    (operand),
    .ret_addr   (ret_addr),
    .irq_enter  (irq_enter),
    .cy_in      (cy_in),
    .ac_in      (ac_in),
    .op_ready_r (op_ready_r),
    .done_r     (done_r),
    .acc_r      (acc_r),
    .sp_r       (sp_r),
    .cy_r       (cy_r),
    .ret_pc_r   (ret_pc_r)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Direct space: E0 and 81 map to registers, other high bytes read zero
  function automatic logic [7:0] rd(input logic [7:0] x);
    if (x == `ADDR_A_REG_SFR) return m_acc;
    if (x == `ADDR_SP_SFR) return m_sp;
    if (x[7]) return 8'h00;
    return m_ram[x];
  endfunction

  task automatic wr(input logic [7:0] x, input logic [7:0] v);
    if (x == `ADDR_A_REG_SFR) m_acc = v;
    else if (x == `ADDR_SP_SFR) m_sp = v;
    else if (!x[7]) m_ram[x] = v;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reference behaviour of one taken request
  task automatic apply(input logic [7:0] opc, input logic [7:0] x,
                       input logic [15:0] ra, input logic irq,
                       input logic ci, input logic ai);
    logic [7:0] v;
    logic [7:0] ad;
    int         t;
    if (irq) opc = `OPC_LONG_CALL;
    case (opc)
      `OPC_ACCUM_TRADE:
      begin
        v = rd(x);
        wr(x, m_acc);
        m_acc = v;
      end
      `OPC_SWAP: m_acc = {m_acc[3:0], m_acc[7:4]};
      `OPC_ROTATE_LEFT: m_acc = {m_acc[6:0], m_acc[7]};
      `OPC_DEC_ADJUST:
      begin
        t = m_acc;
        if (m_acc[3:0] > 4'h9 || ai) t = t + 32'h6;
        if (((t >> 4) & 32'hF) > 32'h9 || ci || t > 32'hFF) t = t + 32'h60;
        m_cy = ci | (t > 32'hFF);
        m_acc = t[7:0];
      end
      `OPC_PUSH:
      begin
        v = rd(x);
        m_sp = m_sp + 8'h01;
        m_ram[m_sp] = v;
      end
      `OPC_POP:
      begin
        v = m_ram[m_sp];
        m_sp = m_sp - 8'h01;
        wr(x, v);
      end
      `OPC_SHORT_CALL, `OPC_LONG_CALL:
      begin
        m_ram[8'(m_sp + 8'h01)] = ra[7:0];
        m_ram[8'(m_sp + 8'h02)] = ra[15:8];
        m_sp = m_sp + 8'h02;
      end
      `OPC_SUB_EXIT, `OPC_ISR_EXIT:
      begin
        m_pc = {m_ram[m_sp], m_ram[8'(m_sp - 8'h01)]};
        m_sp = m_sp - 8'h02;
      end
      default:
        if (opc == `OPC_LOW_FIRST)
        begin
          v = rd(x);
          wr(x, {v[7:4], m_acc[3:0]});
          m_acc = {m_acc[7:4], v[3:0]};
        end
        else if (opc >= `OPC_LOW_IND0 && opc <= `OPC_LOW_LAST)
        begin
          ad = (opc == `OPC_LOW_IND0) ? m_ram[0] :
               (opc == `OPC_LOW_IND1) ? m_ram[1] : {5'h00, opc[2:0]};
          v = m_ram[ad];
          m_ram[ad] = {v[7:4], m_acc[3:0]};
          m_acc = {m_acc[7:4], v[3:0]};
        end
    endcase
  endtask

  // Present one request, hold it until taken, note the expected result
  task automatic do_op(input logic [7:0] opc, input logic [7:0] x,
                       input logic irq);
    logic [31:0] rv;
    rv = xs();
    if (pin_en) rv[17:0] = pin_v;
    op_valid = 1'b1;
    opcode = opc;
    operand = x;
    ret_addr = rv[15:0];
    irq_enter = irq;
    cy_in = rv[16];
    ac_in = rv[17];
    k = 0;
    while (op_ready_r !== 1'b1 && k < 50)
    begin
      @(posedge core_clk);
      #TD;
      k++;
    end
    if (k == 50)
    begin
      chk("ready_wait", 16'h0000, 16'h0001);
      report_and_stop();
    end
    @(posedge core_clk);
    apply(opc, x, rv[15:0], irq, rv[16], rv[17]);
    notes.push_back('{m_acc, m_sp, m_cy, m_pc});
    #TD;
  endtask

  // ************************************************************
  // Result watcher
  // ************************************************************
  always @(negedge core_clk)
    if (done_r === 1'b1)
    begin
      if (notes.size() == 0)
        chk("done_extra", 16'h0000, 16'h0001);
      else
      begin
        nt = notes.pop_front();
        chk("acc", {8'h00, acc_r}, {8'h00, nt.acc});
        chk("sp", {8'h00, sp_r}, {8'h00, nt.sp});
        chk("cy", {15'h0000, cy_r}, {15'h0000, nt.cy});
        chk("ret_pc", ret_pc_r, nt.pc);
      end
    end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    seed = 32'h6B32B057;
    rstn = 1'b0;
    clk_en = 1'b1;
    op_valid = 1'b0;
    opcode = 8'h00;
    operand = 8'h00;
    ret_addr = 16'h0000;
    irq_enter = 1'b0;
    cy_in = 1'b0;
    ac_in = 1'b0;
    m_acc = 8'h00;
    m_sp = `SP_RESET;
    m_cy = 1'b0;
    m_pc = 16'h0000;
    pin_en = 1'b0;
    pin_v = 18'h00000;
    repeat (20) @(posedge core_clk);
    #TD rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    #TD;
    chk("sp_reset", {8'h00, sp_r}, 16'h0007);
    chk("acc_reset", {8'h00, acc_r}, 16'h0000);
    // Return byte 5D parked at 08 is traded in, then adjusted
    pin_en = 1'b1;
    pin_v = 18'h0005D;
    do_op(`OPC_LONG_CALL, 8'h00, 1'b0);
    chk("busy_call", {15'h0000, op_ready_r}, 16'h0000);
    do_op(`OPC_SUB_EXIT, 8'h00, 1'b0);
    do_op(`OPC_ACCUM_TRADE, 8'h08, 1'b0);
    do_op(`OPC_DEC_ADJUST, 8'h00, 1'b0);
    chk("adjust_5d", {8'h00, acc_r}, 16'h0063);
    pin_en = 1'b0;
    // Fill all 256 bytes by pushing; the pointer wraps back to its start
    for (i = 0; i < 256; i++)
    begin
      r = xs();
      do_op(r[0] ? `OPC_DEC_ADJUST : `OPC_ROTATE_LEFT, 8'h00, 1'b0);
      do_op(`OPC_PUSH, `ADDR_A_REG_SFR, 1'b0);
    end
    chk("sp_wrap", {8'h00, sp_r}, 16'h0007);
    a0 = m_acc;
    repeat (4) do_op(`OPC_ROTATE_LEFT, 8'h00, 1'b0);
    chk("rot4", {8'h00, acc_r}, {8'h00, a0[3:0], a0[7:4]});
    do_op(`OPC_SWAP, 8'h00, 1'b0);
    chk("swap", {8'h00, acc_r}, {8'h00, a0});
    // Clock enable low: a pending store must not be taken
    op_valid = 1'b0;
    @(posedge core_clk);
    #TD;
    clk_en = 1'b0;
    op_valid = 1'b1;
    opcode = `OPC_PUSH;
    repeat (4) @(posedge core_clk);
    #TD;
    chk("frozen_sp", {8'h00, sp_r}, {8'h00, m_sp});
    chk("frozen_done", {15'h0000, done_r}, 16'h0000);
    op_valid = 1'b0;
    clk_en = 1'b1;
    @(posedge core_clk);
    #TD;
    // Three pushes then three pops come back in reverse order
    for (i = 0; i < 3; i++)
    begin
      do_op(`OPC_PUSH, `ADDR_A_REG_SFR, 1'b0);
      do_op(`OPC_DEC_ADJUST, 8'h00, 1'b0);
    end
    for (i = 0; i < 3; i++)
      do_op(`OPC_POP, `ADDR_A_REG_SFR, 1'b0);
    // Every low-nibble encoding at least once
    for (i = 32'hD5; i <= 32'hDF; i++)
      do_op(i[7:0], 8'(xs() & 32'h7F), 1'b0);
    do_op(`OPC_LONG_CALL, 8'h00, 1'b0);
    do_op(8'hA5, 8'h00, 1'b1);
    do_op(`OPC_ISR_EXIT, 8'h00, 1'b0);
    do_op(`OPC_SUB_EXIT, 8'h00, 1'b0);
    for (i = 0; i < 600; i++)
    begin
      r = xs();
      do_op(opc_tab[r[20:16] % 14],
            (r[9:8] == 2'b00) ? `ADDR_A_REG_SFR :
            (r[9:8] == 2'b01) ? 8'h90 : {1'b0, r[6:0]},
            r[24] & r[25] & r[26]);
    end
    // Read back each of the 128 low direct bytes twice so the byte is restored
    for (i = 0; i < 128; i++)
    begin
      do_op(`OPC_ACCUM_TRADE, i[7:0], 1'b0);
      do_op(`OPC_ACCUM_TRADE, i[7:0], 1'b0);
    end
    op_valid = 1'b0;
    k = 0;
    while (notes.size() != 0 && k < 20)
    begin
      @(posedge core_clk);
      k++;
    end
    if (notes.size() != 0) chk("done_missing", 16'h0000, 16'h0001);
    report_and_stop();
  end
endmodule // accum_exchange_stack_ops_tb_top
`default_nettype wire
